// ---- rsa_top.sv ----
// two-wire target access with bus timeout and the BCD seconds register
`timescale 1ns/1ps
module rsa_top
    import rsa_pkg::*;
#(
    parameter int TMO_CYCLES = TMO_CYC,
    parameter int TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // serial bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // protection and time outputs
    input wire logic i_wr_protect,
    output logic [7:0] o_seconds,
    output logic o_min_carry,
    output logic o_busy
);
    // pin synchronisers: stage 1 only feeds stage 2
    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    logic wp_s1_r, wp_s2_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_s3_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_s3_r <= 1'b1;
            wp_s1_r <= 1'b0;
            wp_s2_r <= 1'b0;
        end else begin
            scl_s1_r <= i_scl;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= i_sda;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
            wp_s1_r <= i_wr_protect;
            wp_s2_r <= wp_s1_r;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_s2_r && !scl_s3_r;
    assign scl_fall = !scl_s2_r && scl_s3_r;
    assign start_det = scl_s2_r && scl_s3_r && !sda_s2_r && sda_s3_r;
    assign stop_det = scl_s2_r && scl_s3_r && sda_s2_r && !sda_s3_r;

    // write queue between bus engine and register
    rsa_strm_if #(.W(FIFO_W)) wq_in ();
    rsa_strm_if #(.W(FIFO_W)) wq_out ();

    rsa_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wq (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .s_in(wq_in),
        .s_out(wq_out)
    );

    // bus engine state
    rsa_state_t st_r, st_nxt;
    logic [3:0] bcnt_r, bcnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic rw_r, rw_nxt;
    logic ack_r, ack_nxt;
    logic sda_lo_r, sda_lo_nxt;
    logic [CNT_W-1:0] tmo_r, tmo_nxt;
    logic push;
    logic [7:0] sec_r;
    logic [7:0] rd_byte;

    // reads are never gated by protection
    assign rd_byte = (ptr_r == SEC_OFS) ? sec_r : 8'h00;
    assign wq_in.valid = push;
    assign wq_in.data = {ptr_r, sh_r};

    always_comb begin
        st_nxt = st_r;
        bcnt_nxt = bcnt_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        ack_nxt = ack_r;
        sda_lo_nxt = sda_lo_r;
        push = 1'b0;
        // host is expected to close within the window; we enforce it anyway
        tmo_nxt = (st_r == ST_IDLE) ? '0 : tmo_r + 1'b1;
        if (start_det) begin
            st_nxt = ST_ADDR;
            bcnt_nxt = 4'h0;
            sda_lo_nxt = 1'b0;
            // a repeated start keeps the watchdog running until the stop
        end else if (stop_det) begin
            st_nxt = ST_IDLE;
            sda_lo_nxt = 1'b0;
        end else if (st_r != ST_IDLE && tmo_r >= CNT_W'(TMO_CYCLES - 1)) begin
            // interface reset: release the line and wait for a new start
            st_nxt = ST_IDLE;
            sda_lo_nxt = 1'b0;
        end else if (scl_rise) begin
            unique case (st_r)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    sh_nxt = {sh_r[6:0], sda_s2_r};
                    bcnt_nxt = bcnt_r + 4'h1;
                end
                ST_RDATA: begin
                    bcnt_nxt = bcnt_r + 4'h1;
                end
                ST_RACK: begin
                    ack_nxt = !sda_s2_r;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (st_r)
                ST_ADDR: begin
                    if (bcnt_r == 4'h8) begin
                        if (sh_r[7:1] == DEV_ADDR) begin
                            rw_nxt = sh_r[0];
                            sda_lo_nxt = 1'b1;
                            st_nxt = ST_AACK;
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    bcnt_nxt = 4'h0;
                    if (rw_r) begin
                        sh_nxt = rd_byte;
                        sda_lo_nxt = !rd_byte[7];
                        st_nxt = ST_RDATA;
                    end else begin
                        sda_lo_nxt = 1'b0;
                        st_nxt = ST_PTR;
                    end
                end
                ST_PTR: begin
                    if (bcnt_r == 4'h8) begin
                        ptr_nxt = sh_r;
                        sda_lo_nxt = 1'b1;
                        st_nxt = ST_PACK;
                    end
                end
                ST_PACK: begin
                    bcnt_nxt = 4'h0;
                    sda_lo_nxt = 1'b0;
                    st_nxt = ST_WDATA;
                end
                ST_WDATA: begin
                    if (bcnt_r == 4'h8) begin
                        // a full queue is refused with a not-acknowledge
                        if (wq_in.ready) begin
                            push = 1'b1;
                            sda_lo_nxt = 1'b1;
                            st_nxt = ST_WACK;
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                end
                ST_WACK: begin
                    ptr_nxt = ptr_r + 8'h01;
                    bcnt_nxt = 4'h0;
                    sda_lo_nxt = 1'b0;
                    st_nxt = ST_WDATA;
                end
                ST_RDATA: begin
                    if (bcnt_r == 4'h8) begin
                        sda_lo_nxt = 1'b0;
                        st_nxt = ST_RACK;
                    end else begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        sda_lo_nxt = !sh_r[6];
                    end
                end
                ST_RACK: begin
                    if (ack_r) begin
                        ptr_nxt = ptr_r + 8'h01;
                        bcnt_nxt = 4'h0;
                        sh_nxt = (ptr_r + 8'h01 == SEC_OFS) ? sec_r : 8'h00;
                        sda_lo_nxt = (ptr_r + 8'h01 == SEC_OFS) ? !sec_r[7] : 1'b1;
                        st_nxt = ST_RDATA;
                    end else begin
                        st_nxt = ST_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_r <= ST_IDLE;
            bcnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            sda_lo_r <= 1'b0;
            tmo_r <= '0;
        end else begin
            st_r <= st_nxt;
            bcnt_r <= bcnt_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            ack_r <= ack_nxt;
            sda_lo_r <= sda_lo_nxt;
            tmo_r <= tmo_nxt;
        end
    end

    // seconds register; queued writes apply only between transactions so a
    // multi-byte burst lands atomically and the queue can really back up
    logic [7:0] sec_nxt;
    logic [CNT_W-1:0] div_r, div_nxt;
    logic carry_r, carry_nxt;
    logic tick, wr_ok;
    logic [7:0] wr_data;

    assign wq_out.ready = (st_r == ST_IDLE);
    assign wr_data = wq_out.data[7:0];
    assign tick = (div_r == CNT_W'(TICK_CYCLES - 1));
    // out-of-range BCD is dropped so the count never leaves 00..59
    assign wr_ok = wq_out.valid && wq_out.ready && (wq_out.data[15:8] == SEC_OFS)
                   && !wp_s2_r
                   && (wr_data[7:4] <= SEC_TENS_MAX) && (wr_data[3:0] <= BCD_MAX);

    always_comb begin
        div_nxt = tick ? '0 : div_r + 1'b1;
        sec_nxt = sec_r;
        carry_nxt = 1'b0;
        if (wr_ok) begin
            sec_nxt = wr_data;
        end else if (tick) begin
            if (sec_r[3:0] != BCD_MAX) begin
                sec_nxt = {sec_r[7:4], sec_r[3:0] + 4'h1};
            end else if (sec_r[7:4] != SEC_TENS_MAX) begin
                sec_nxt = {sec_r[7:4] + 4'h1, 4'h0};
            end else begin
                sec_nxt = SEC_RST;
                carry_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sec_r <= SEC_RST;
            div_r <= '0;
            carry_r <= 1'b0;
        end else begin
            sec_r <= sec_nxt;
            div_r <= div_nxt;
            carry_r <= carry_nxt;
        end
    end

    assign o_sda = 1'b0;
    assign o_sda_oe = sda_lo_r;
    assign o_seconds = sec_r;
    assign o_min_carry = carry_r;
    assign o_busy = (st_r != ST_IDLE);
endmodule : rsa_top

// ---- rsa_pkg.sv ----
// constants shared by the serial access and seconds logic
// Function
// - 950 ms without stop resets serial interface
// - seconds held at offset 00h as BCD
// - seconds value stays within 00 to 59
// - seconds always readable, never blocked
// - write protection blocks seconds writes unchanged
package rsa_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int TMO_MS = 950;
    localparam int TMO_CYC = TMO_MS * CYC_PER_MS;
    localparam int TICK_MS = 1000;
    localparam int TICK_CYC = TICK_MS * CYC_PER_MS;
    localparam int CNT_W = 26;
    // bus address of the device; arbitrary value
    localparam logic [6:0] DEV_ADDR = 7'h52;
    localparam logic [7:0] SEC_OFS = 8'h00;
    localparam logic [7:0] SEC_RST = 8'h00;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] SEC_TENS_MAX = 4'h5;
    localparam int FIFO_W = 16;
    localparam int FIFO_DEPTH = 8;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK,
        ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
    } rsa_state_t;
endpackage : rsa_pkg

// ---- rsa_strm_if.sv ----
// valid/ready word stream into the write queue from the bus engine and out of it to the seconds register
`timescale 1ns/1ps
interface rsa_strm_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : rsa_strm_if

// ---- rsa_fifo.sv ----
// synchronous fifo holding received register writes
`timescale 1ns/1ps
module rsa_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // fill and drain sides
    rsa_strm_if.snk s_in,
    rsa_strm_if.src s_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic full, empty, push, pop;

    assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign empty = (wp_r == rp_r);
    assign s_in.ready = !full;
    assign s_out.valid = !empty;
    assign s_out.data = mem[rp_r[AW-1:0]];
    assign push = s_in.valid && !full;
    assign pop = s_out.ready && !empty;

    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (push) begin
            wp_nxt = wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = rp_r + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= s_in.data;
        end
    end
endmodule : rsa_fifo

// ---- rsa_top_props.sv ----
// concurrent checks on the seconds register and the bus watchdog
`timescale 1ns/1ps
module rsa_top_props
    import rsa_pkg::*;
#(
    parameter int TMO_CYCLES = TMO_CYC,
    parameter int TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // watched ports
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic i_wr_protect,
    input wire logic [7:0] o_seconds,
    input wire logic o_min_carry,
    input wire logic o_busy
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    int busy_cnt_r;
    int busy_cnt_nxt;
    function automatic logic [7:0] bcd_inc(input logic [7:0] s);
        if (s[3:0] != BCD_MAX) return s + 8'h01;
        if (s[7:4] != SEC_TENS_MAX) return {s[7:4] + 4'h1, 4'h0};
        return 8'h00;
    endfunction : bcd_inc
    always_comb begin
        busy_cnt_nxt = o_busy ? busy_cnt_r + 1 : 0;
    end
    always_ff @(posedge i_ref_clk) begin
        busy_cnt_r <= i_rst ? 0 : busy_cnt_nxt;
    end
    bcd_range_a: assert property (o_seconds[3:0] <= BCD_MAX && o_seconds[7:4] <= SEC_TENS_MAX)
        else $error("seconds left bcd range");
    carry_zero_a: assert property (o_min_carry |-> o_seconds == 8'h00)
        else $error("carry without zero seconds");
    carry_from_a: assert property (o_min_carry |-> $past(o_seconds) == 8'h59)
        else $error("carry not from 59");
    carry_pulse_a: assert property (o_min_carry |=> !o_min_carry)
        else $error("carry longer than one cycle");
    // the pin takes three edges to gate the drain, so look that far back
    protect_hold_a: assert property ($past(i_wr_protect, 3) |-> o_seconds == $past(o_seconds)
        || o_seconds == bcd_inc($past(o_seconds)))
        else $error("seconds changed by a write under protection");
    bus_timeout_a: assert property (busy_cnt_r <= TMO_CYCLES + 4)
        else $error("transaction outlived the watchdog");
    idle_release_a: assert property (!o_busy && !$past(o_busy) |-> !o_sda_oe)
        else $error("data line driven while idle");
    reset_quiet_a: assert property (disable iff (1'b0) i_rst |=> !o_busy && !o_sda_oe
        && o_seconds == SEC_RST && !o_min_carry)
        else $error("outputs not cleared by reset");
endmodule : rsa_top_props

// ---- rsa_host.sv ----
// behavioural bus controller driving clock and data, 160 ns bit period
`timescale 1ns/1ps
module rsa_host (
    input wire logic i_ref_clk,
    input wire logic i_sda_line,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic q;
        repeat (2) @(negedge i_ref_clk);
    endtask : q
    task automatic start;
        o_sda = 1'b1;
        q;
        o_scl = 1'b1;
        q;
        o_sda = 1'b0;
        q;
        o_scl = 1'b0;
        q;
    endtask : start
    // clock is left high after stop: it stands still between frames
    task automatic stop;
        o_sda = 1'b0;
        q;
        o_scl = 1'b1;
        q;
        o_sda = 1'b1;
        q;
    endtask : stop
    task automatic bitx(input logic b, output logic r);
        o_sda = b;
        q;
        q;
        o_scl = 1'b1;
        q;
        r = i_sda_line;
        q;
        o_scl = 1'b0;
    endtask : bitx
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask : wr
    task automatic rd(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(nack, r);
    endtask : rd
endmodule : rsa_host

// ---- tb_rtc_serial_access_timeout_seconds.sv ----
// register-level bench for the seconds register and bus watchdog
`timescale 1ns/1ps
module tb_rtc_serial_access_timeout_seconds
    import rsa_pkg::*;
;
    localparam int TMO = 2000;
    localparam int TICK = 2500;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic prot = 1'b0;
    logic scl, hsda, oe, sda_out, carry, busy;
    logic [7:0] secs;
    wire logic sda_line = hsda & ~oe;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    logic c, a;
    logic [7:0] d;
    always #10 clk = ~clk;
    rsa_top #(.TMO_CYCLES(TMO), .TICK_CYCLES(TICK)) DUT (.i_ref_clk(clk), .i_rst(rst),
        .i_scl(scl), .i_sda(sda_line), .o_sda(sda_out), .o_sda_oe(oe),
        .i_wr_protect(prot), .o_seconds(secs), .o_min_carry(carry), .o_busy(busy));
    rsa_host u_host (.i_ref_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda(hsda));
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] v);
        u_host.start;
        u_host.wr({DEV_ADDR, 1'b0}, a);
        u_host.wr(SEC_OFS, a);
        u_host.wr(v, a);
        chk("write ack", 1, a);
        u_host.stop;
        repeat (8) @(negedge clk);
    endtask : reg_wr
    task automatic reg_rd(output logic [7:0] v);
        u_host.start;
        u_host.wr({DEV_ADDR, 1'b0}, a);
        u_host.wr(SEC_OFS, a);
        u_host.start;
        u_host.wr({DEV_ADDR, 1'b1}, a);
        u_host.rd(1'b1, v);
        u_host.stop;
    endtask : reg_rd
    // returns cycles until the seconds value moves and the carry seen then
    task automatic wait_tick(output int k, output logic cy);
        logic [7:0] s;
        s = secs;
        k = 0;
        while (secs === s && k < TICK + 50) begin
            @(negedge clk);
            k++;
        end
        cy = carry;
    endtask : wait_tick
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            complete_run;
        end
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk("reset seconds", SEC_RST, secs);
        chk("reset busy", 0, busy);
        chk("sda drive value", 0, sda_out);
        wait_tick(n, c);
        wait_tick(n, c);
        chk("tick period", TICK, n);
        chk("seconds step", 8'h02, secs);
        wait_tick(n, c);
        reg_wr(8'h58);
        chk("written seconds", 8'h58, secs);
        prot = 1'b1;
        reg_rd(d);
        chk("read under protect", 8'h58, d);
        reg_wr(8'h11);
        chk("protected write", 8'h58, secs);
        prot = 1'b0;
        reg_wr(8'h5A);
        reg_wr(8'h60);
        chk("invalid bcd write", 8'h58, secs);
        // another target address must be left unanswered
        u_host.start;
        u_host.wr({DEV_ADDR ^ 7'h01, 1'b0}, a);
        chk("foreign address ack", 0, a);
        u_host.stop;
        // a byte aimed at another offset must not reach the seconds
        u_host.start;
        u_host.wr({DEV_ADDR, 1'b0}, a);
        u_host.wr(SEC_OFS + 8'h01, a);
        u_host.wr(8'h22, a);
        u_host.stop;
        repeat (8) @(negedge clk);
        chk("other offset write", 8'h58, secs);
        wait_tick(n, c);
        chk("seconds 59", 8'h59, secs);
        wait_tick(n, c);
        chk("rollover", 8'h00, secs);
        chk("minute carry", 1, c);
        u_host.start;
        u_host.wr({DEV_ADDR, 1'b0}, a);
        repeat (TMO - 200) @(negedge clk);
        chk("busy before timeout", 1, busy);
        repeat (220) @(negedge clk);
        chk("timeout busy", 0, busy);
        chk("timeout release", 0, oe);
        u_host.stop;
        reg_wr(8'h33);
        chk("after timeout", 8'h33, secs);
        complete_run;
    end
endmodule : tb_rtc_serial_access_timeout_seconds
bind rsa_top rsa_top_props #(.TMO_CYCLES(TMO_CYCLES), .TICK_CYCLES(TICK_CYCLES)) u_props (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .i_wr_protect(i_wr_protect), .o_seconds(o_seconds),
    .o_min_carry(o_min_carry), .o_busy(o_busy));
